// *** sdp_chk.sv ***
// Link and converter output checks
`timescale 1ns/10ps
`default_nettype none
module sdp_chk
   import sdp_pkg::*;
(
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        sclk,
   input wire logic        sync_n,
   input wire logic        din,
   input wire logic [11:0] dac_code,
   input wire logic [1:0]  op_mode,
   input wire logic        analog_en,
   input wire logic        pull_5k_en,
   input wire logic        pull_100k_en,
   input wire logic        update_pulse
);
   logic [4:0] edge_r;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // Falling link edges since frame start, held until next frame
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         edge_r <= 5'h0;
      end else if ($fell(sync_n)) begin
         edge_r <= 5'h0;
      end else if ($fell(sclk) && !sync_n) begin
         edge_r <= edge_r + 5'h1;
      end
   end
   a_pulse_one: assert property (update_pulse |=> !update_pulse)
      else $error("update pulse too long");
   a_edge_count: assert property (update_pulse |-> edge_r == 5'h10)
      else $error("update without sixteen edges");
   a_normal_run: assert property (analog_en == (op_mode == SDP_NORMAL))
      else $error("analog enable wrong");
   a_pull_5k: assert property (pull_5k_en == (op_mode == SDP_PD_5K))
      else $error("5k pull wrong");
   a_pull_100k: assert property (pull_100k_en == (op_mode == SDP_PD_100K))
      else $error("100k pull wrong");
   // A change of code or mode only next to an applied word
   a_code_held: assert property (($changed(dac_code) || $changed(op_mode)) |->
      (update_pulse || $past(update_pulse))) else $error("code moved without update");
   a_din_steady: assert property ($fell(sclk) |-> $stable(din))
      else $error("data moved at sample edge");
   a_sclk_idle: assert property (sync_n |-> !sclk)
      else $error("link clock high outside frame");
   c_hiz: cover property (update_pulse ##1 op_mode == SDP_PD_HIZ);
   c_full: cover property (update_pulse ##1 dac_code == 12'hfff);
   c_gap: cover property ($rose(sync_n) ##[1:8] $fell(sync_n));
endmodule // sdp_chk
`default_nettype wire

// *** sdp_device.sv ***
// Converter end: serial input word, code and operating mode
// Behaviour
// [RQ1] Mode bits 13:12; 00 is normal
// [RQ2] 01 5k, 10 100k, 11 high impedance
// [RQ3] Power-down kills analog, port keeps working
// [RQ4] Host starts each write: frame select falls
// [RQ5] Shift data on falling clock, frame low
// [RQ6] Sixteenth edge applies code and mode
// [RQ7] Host may hold or raise frame after
// [RQ8] Frame high gap; next fall restarts
// [RQ9] Host parks frame and data low idle
// [RQ10] First two bits ignored, next mode
// [RQ11] Early frame rise discards the word
// [RQ12] Host sends most significant bit first
// [RQ13] Two bytes allowed within one frame
// [RQ14] Host changes data on rising clock
// [RQ15] Reset clears code, output at zero
// [RQ16] Code is unsigned binary 0 to 4095
// [RQ17] Last twelve bits are the code
`timescale 1ns/10ps
`default_nettype none
module sdp_device
   import sdp_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          resetn,
   sdp_link_if.device         link,
   output logic [11:0]        dac_code,
   output logic [1:0]         op_mode,
   output logic               analog_en,
   output logic               pull_5k_en,
   output logic               pull_100k_en,
   output logic               update_pulse
);
   typedef struct packed {
      logic [15:0] word;
      logic [4:0]  cnt;
      logic        done;
      logic        sclk_d;
      logic        sync_d;
      logic [11:0] code;
      logic [1:0]  mode;
      logic        an_en;
      logic        p5k;
      logic        p100k;
      logic        upd;
   } sdp_dev_s;

   sdp_dev_s st_r;
   sdp_dev_s st_nxt;
   logic     sclk_s;
   logic     sync_n_s;
   logic     din_s;

   // Pins come from another domain
   sdp_sync2 #(.W(3)) u_sync (
      .clock   (clock),
      .resetn  (resetn),
      .d       ({link.sclk, link.sync_n, link.din}),
      .rst_val (3'h0),
      .q       ({sclk_s, sync_n_s, din_s})
   );

   // Next-state logic
   always_comb begin
      logic       fall;
      logic [1:0] m;
      fall   = st_r.sclk_d & ~sclk_s;
      m      = st_r.word[1:0];
      st_nxt = st_r;
      st_nxt.sclk_d = sclk_s;
      st_nxt.sync_d = sync_n_s;
      st_nxt.upd    = 1'b0;
      if (sync_n_s) begin
         // Frame high: a short word is dropped, code kept
         st_nxt.word = WORD_RESET; // RQ11
         st_nxt.cnt  = '0;         // RQ8
         st_nxt.done = 1'b0;
      end else if (fall && !st_r.done) begin
         st_nxt.word = {st_r.word[14:0], din_s}; // RQ5 RQ12
         st_nxt.cnt  = st_r.cnt + 5'd1;
         if (st_r.cnt == 5'(WORD_BITS - 1)) begin
            // Extra edges after the word are ignored until frame rises
            st_nxt.done = 1'b1; // RQ7
            st_nxt.upd  = 1'b1; // RQ6
            st_nxt.code = {st_r.word[CODE_HI-1:0], din_s}; // RQ17 RQ16
            m           = st_r.word[MODE_HI-1:MODE_LO-1];  // RQ10
            st_nxt.mode = m;                               // RQ1
            st_nxt.an_en = (m == SDP_NORMAL); // RQ3
            st_nxt.p5k   = (m == SDP_PD_5K);  // RQ2
            st_nxt.p100k = (m == SDP_PD_100K); // RQ2
         end
      end
   end

   // State register; code starts at zero, output normal
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r       <= '0; // RQ15
         st_r.sync_d <= 1'b1;
         st_r.an_en <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dac_code     = st_r.code;
   assign op_mode      = st_r.mode;
   assign analog_en    = st_r.an_en;
   assign pull_5k_en   = st_r.p5k;
   assign pull_100k_en = st_r.p100k;
   assign update_pulse = st_r.upd;
endmodule // sdp_device
`default_nettype wire

// *** sdp_host.sv ***
// Serial master end with an APB command register
`timescale 1ns/10ps
`default_nettype none
module sdp_host
   import sdp_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   sdp_link_if.host         link
);
   typedef enum logic [3:0] {
      H_IDLE  = 4'b0001,
      H_LOW   = 4'b0010,
      H_HIGH  = 4'b0100,
      H_GAP   = 4'b1000
   } sdp_hst_e;

   typedef struct packed {
      sdp_hst_e    state;
      logic [15:0] sh;
      logic [4:0]  bits;
      logic [7:0]  tmr;
      logic        sclk;
      logic        sync_n;
      logic        din;
      logic [31:0] rdata;
   } sdp_hst_s;

   sdp_hst_s st_r;
   sdp_hst_s st_nxt;
   logic     acc;
   logic     busy;

   assign acc  = psel & penable;
   assign busy = (st_r.state != H_IDLE);

   // Bus answers in the first access cycle, read data from a flop
   // Read data is loaded only in a setup cycle, so it still stands at the ready edge
   always_comb begin
      st_nxt = st_r;
      if (psel && !penable) begin
         st_nxt.rdata = '0;
         if (!pwrite && paddr == ADDR_STATUS)
            st_nxt.rdata[STATUS_BUSY] = busy;
      end
      unique case (st_r.state)
         H_IDLE: begin
            st_nxt.sync_n = 1'b0; // RQ9
            st_nxt.din    = 1'b0;
            st_nxt.sclk   = 1'b0;
            // Write while busy is dropped; software polls status
            if (acc && pwrite && paddr == ADDR_TX) begin
               st_nxt.sh     = pwdata[15:0];
               st_nxt.sync_n = 1'b1; // RQ4
               st_nxt.tmr    = 8'(IDLE_CYC);
               st_nxt.state  = H_GAP;
               st_nxt.bits   = 5'd0;
            end
         end
         H_GAP: begin
            // High then falling edge starts the frame
            if (st_r.tmr != 8'd0) begin
               st_nxt.tmr = st_r.tmr - 8'd1; // RQ8
            end else if (st_r.sync_n) begin
               st_nxt.sync_n = 1'b0; // RQ4
               st_nxt.tmr    = 8'(SCLK_HALF_CYC);
            end else if (st_r.bits == 5'(WORD_BITS)) begin
               st_nxt.state = H_IDLE;
            end else begin
               st_nxt.sclk  = 1'b1; // RQ14
               st_nxt.din   = st_r.sh[15]; // RQ12
               st_nxt.sh    = {st_r.sh[14:0], 1'b0};
               st_nxt.tmr   = 8'(SCLK_HALF_CYC - 1);
               st_nxt.state = H_HIGH;
            end
         end
         H_HIGH: begin
            if (st_r.tmr != 8'd0) begin
               st_nxt.tmr = st_r.tmr - 8'd1;
            end else begin
               st_nxt.sclk  = 1'b0; // RQ5
               st_nxt.bits  = st_r.bits + 5'd1;
               st_nxt.tmr   = 8'(SCLK_HALF_CYC - 1);
               st_nxt.state = H_LOW;
            end
         end
         H_LOW: begin
            if (st_r.tmr != 8'd0) begin
               st_nxt.tmr = st_r.tmr - 8'd1;
            end else if (st_r.bits == 5'(WORD_BITS)) begin
               st_nxt.din    = 1'b0;
               st_nxt.sync_n = 1'b1; // RQ7
               st_nxt.tmr    = 8'(IDLE_CYC);
               st_nxt.state  = H_GAP;
            end else begin
               st_nxt.sclk  = 1'b1;
               st_nxt.din   = st_r.sh[15];
               st_nxt.sh    = {st_r.sh[14:0], 1'b0};
               st_nxt.tmr   = 8'(SCLK_HALF_CYC - 1);
               st_nxt.state = H_HIGH;
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r       <= '0;
         st_r.state <= H_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata      = st_r.rdata;
   assign pready      = 1'b1;
   assign pslverr     = 1'b0;
   assign link.sclk   = st_r.sclk;
   assign link.sync_n = st_r.sync_n;
   assign link.din    = st_r.din;
endmodule // sdp_host
`default_nettype wire

// *** sdp_link_if.sv ***
// Three-wire link between serial master and converter port
`timescale 1ns/10ps
`default_nettype none
interface sdp_link_if;
   logic sclk;
   logic sync_n;
   logic din;
   modport host   (output sclk, output sync_n, output din);
   modport device (input sclk, input sync_n, input din);
endinterface
`default_nettype wire

// *** sdp_pkg.sv ***
// Shared constants and types for the serial converter write port
package sdp_pkg;
   localparam int unsigned WORD_BITS     = 16;
   localparam int unsigned CODE_BITS     = 12;
   localparam int unsigned MODE_HI       = 13;
   localparam int unsigned MODE_LO       = 12;
   localparam int unsigned CODE_HI       = 11;
   localparam logic [11:0] CODE_RESET    = 12'h000;
   localparam logic [1:0]  MODE_RESET    = 2'h0;
   localparam logic [15:0] WORD_RESET    = 16'h0000;
   // Link clock is our clock divided by twice this half period count
   localparam int unsigned SCLK_HALF_CYC = 4;
   // Frame select high time between frames is this count plus one cycle
   localparam int unsigned IDLE_CYC      = 4;
   // APB register byte addresses
   localparam logic [7:0]  ADDR_TX       = 8'h00;
   localparam logic [7:0]  ADDR_STATUS   = 8'h04;
   localparam int unsigned STATUS_BUSY   = 0;

   typedef enum logic [1:0] {
      SDP_NORMAL  = 2'b00,
      SDP_PD_5K   = 2'b01,
      SDP_PD_100K = 2'b10,
      SDP_PD_HIZ  = 2'b11
   } sdp_mode_e;
endpackage

// *** sdp_sync2.sv ***
// Two flip-flop synchroniser for link pins
`timescale 1ns/10ps
`default_nettype none
module sdp_sync2 #(
   parameter int unsigned W = 3
) (
   input  wire logic         clock,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   input  wire logic [W-1:0] rst_val,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;
   // First stage feeds only the second
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // sdp_sync2
`default_nettype wire

// *** serial_dac_input_port_tb_top.sv ***
// Bench: host and converter joined, plus a bench-driven converter
`timescale 1ns/10ps
`default_nettype none
module serial_dac_input_port_tb_top;
   import sdp_pkg::*;
   logic        clock, resetn, psel, penable, pwrite, pready, an1, p5, p100, upd1;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] code1, code2;
   logic [1:0]  mode1, mode2;
   logic [15:0] w;
   int          miscompares, checked, i;
   int unsigned seed, exp_code, exp_mode;
   sdp_link_if link1 ();
   sdp_link_if link2 ();
   sdp_host sdp_host_i (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(), .link(link1.host));
   sdp_device sdp_device_i (.clock(clock), .resetn(resetn), .link(link1.device),
      .dac_code(code1), .op_mode(mode1), .analog_en(an1), .pull_5k_en(p5),
      .pull_100k_en(p100), .update_pulse(upd1));
   // Second converter takes broken frames from the bench
   sdp_device sdp_device_x_i (.clock(clock), .resetn(resetn), .link(link2.device),
      .dac_code(code2), .op_mode(mode2), .analog_en(), .pull_5k_en(),
      .pull_100k_en(), .update_pulse());
   sdp_chk sdp_chk_i (.clock(clock), .resetn(resetn), .sclk(link1.sclk),
      .sync_n(link1.sync_n), .din(link1.din), .dac_code(code1), .op_mode(mode1),
      .analog_en(an1), .pull_5k_en(p5), .pull_100k_en(p100), .update_pulse(upd1));
   // 25 MHz clock
   initial begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // A spent wait bound ends the run as a failure
   task automatic lim(input int n, input int m);
      if (n >= m) begin
         miscompares++;
         give_verdict();
      end
   endtask
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // One APB transfer, request held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'h1 && n < 50);
      lim(n, 50);
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Word through the host; dup adds a write while busy, which must be dropped
   task automatic send(input logic [15:0] v, input logic dup);
      int n;
      n = 0;
      do begin
         apb(1'h0, ADDR_STATUS, 32'h0);
         n++;
      end while (rd[STATUS_BUSY] !== 1'h0 && n < 200);
      lim(n, 200);
      apb(1'h1, ADDR_TX, {16'h0, v});
      if (dup) apb(1'h1, ADDR_TX, {16'h0, ~v});
      exp_code = v[11:0];
      exp_mode = v[13:12];
      for (n = 0; upd1 !== 1'h1 && n < 400; n++) @(posedge clock);
      lim(n, 400);
      @(posedge clock);
      #1;
      chk("code", code1, 16'(exp_code));
      chk("mode", mode1, 16'(exp_mode));
      chk("analog", an1, 16'(exp_mode == 0));
      chk("pull5k", p5, 16'(exp_mode == 1));
      chk("pull100k", p100, 16'(exp_mode == 2));
   endtask
   // Bench frame of nb bits, MSB first, data changed on rising link clock
   task automatic frame2(input logic [15:0] v, input int nb);
      int b;
      @(posedge clock);
      link2.sync_n <= 1'h1;
      repeat (5) @(posedge clock);
      link2.sync_n <= 1'h0;
      // Frame select stays low across all nb bits; the whole word, both byte halves, only when nb is 16
      for (b = 15; b > 15 - nb; b--) begin
         repeat (4) @(posedge clock);
         link2.sclk <= 1'h1;
         link2.din <= v[b];
         repeat (4) @(posedge clock);
         link2.sclk <= 1'h0;
      end
      repeat (4) @(posedge clock);
      link2.sync_n <= 1'h1;
      link2.din <= 1'h0;
      repeat (20) @(posedge clock);
      link2.sync_n <= 1'h0;
   endtask
   initial begin
      {resetn, psel, penable, pwrite} = 4'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      {link2.sclk, link2.sync_n, link2.din} = 3'h0;
      seed = 87557;
      repeat (5) @(posedge clock);
      resetn <= 1'h1;
      @(posedge clock);
      #1;
      chk("reset code", code1, 16'h0);
      chk("reset mode", mode1, 16'h0);
      apb(1'h0, 8'h08, 32'h0);
      chk("unmapped", rd[15:0], 16'h0);
      // Every mode, code boundaries, then random words
      for (i = 0; i < 8; i++) begin
         w = 16'(xs());
         w[13:12] = i[1:0];
         if (i == 0) w[11:0] = 12'hfff;
         if (i == 1) w[11:0] = 12'h000;
         send(w, i == 2);
      end
      $display("host link test done");
      frame2(16'h2abc, 16);
      chk("x code", code2, 16'h0abc);
      frame2(16'hc555, 10);
      frame2(16'h5aa5, 15);
      chk("abort code", code2, 16'h0abc);
      chk("abort mode", mode2, 16'h2);
      frame2(16'hc123, 16);
      chk("restart code", code2, 16'h0123);
      chk("restart mode", mode2, 16'h0);
      $display("abort test done");
      give_verdict();
   end
endmodule // serial_dac_input_port_tb_top
`default_nettype wire
